// >>> verilog/accel_id_consts.svh
// Constants of the acceleration and identification response slice.
// Assumes inclusion by the response slice, nothing else.
`ifndef ACCEL_ID_CONSTS_SVH
`define ACCEL_ID_CONSTS_SVH
// Register indices on the plain register port
`define OFS_FORMAT_CTRL      4'h0
`define OFS_DEVICE_CFG       4'h1
`define OFS_DEVICE_CFG_ONE   4'h2
`define OFS_DEVICE_ADDR      4'h3
`define OFS_LAST_RESPONSE    4'h4
`define OFS_RESPONSE_LEN     4'h5
`define OFS_COUNTERS         4'h6
// Reset values
`define RST_FORMAT_CTRL      2'h0
`define RST_DEVICE_CFG       8'h00
`define RST_DEVICE_CFG_ONE   2'h0
`define RST_DEVICE_ADDR      4'h0
// Field positions
`define POS_ENH_LONG         0
`define POS_ENH_SHORT        1
`define POS_ID_SELECT        7
// Command codes and addresses
`define CODE_READ_ACCEL      4'h2
`define CODE_UNIMPLEMENTED   4'h3
`define CODE_REQUEST_ID      4'h4
`define GLOBAL_ADDR          4'h0
// Response lengths in bits
`define LEN_LONG             5'h10
`define LEN_SHORT_MIN        5'h08
`define LEN_SHORT_MAX        5'h0f
`define LEN_FULL_ACCEL       5'h0a
`endif

// >>> verilog/accel_id_pkg.sv
// Types shared by the response slice and its bench.
// Assumes the framing logic hands over one decoded command per pulse.
package accel_id_pkg;

  // Command format as decoded by the framing logic
  typedef enum logic [3:0] {
    FMT_STD_LONG  = 4'b0001,
    FMT_STD_SHORT = 4'b0010,
    FMT_ENH_LONG  = 4'b0100,
    FMT_ENH_SHORT = 4'b1000
  } format_type;

  typedef struct packed {
    format_type  format;
    logic [3:0]  addr;
    logic [3:0]  code;
    logic [7:0]  data;
    logic        crcOk;
    logic [4:0]  len;
  } command_type;

  typedef struct packed {
    logic [15:0] data;
    logic [4:0]  len;
  } response_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECIDE = 3'b010,
    ST_REPLY  = 3'b100
  } state_type;

endpackage

// >>> verilog/accel_response_id_query.sv
// Decode of acceleration and identification commands and reply formatting.
// Assumes framing, CRC check and bit timing sit outside and give one
// command per cmdValid pulse; the reply is handed back as a word and length.
`timescale 1ns/1ps
`include "accel_id_consts.svh"

module accel_response_id_query
  import accel_id_pkg::*;
#(
  parameter int          ACCEL_WIDTH = 10,
  parameter logic [2:0]  VERSION_ID  = 3'h1,
  // Arbitrary identifier value; bit 3 is replaced by the select bit
  parameter logic [4:0]  ID_BASE     = 5'h01
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Command from the framing logic
  input  wire logic                   cmdValid,
  input  command_type                 cmd,
  // Measurement path and device state
  input  wire logic [ACCEL_WIDTH-1:0] accelResult,
  input  wire logic                   internalError,
  input  wire logic                   selfTestActive,
  // Reply to the framing logic
  output logic                        respValid,
  output response_type                resp,
  output logic                        cmdDiscard,
  // Register port
  input  wire logic [3:0]             regAddr,
  input  wire logic [15:0]            regWrData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic [15:0]                 regRdData
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Keep the top bits that fit a short width, never turning a live
  // result into the error code
  function automatic logic [9:0] truncate_accel(
    input logic [9:0] ad,
    input logic [4:0] len
  );
    logic [9:0] t;
    t = ad;
    if (len == `LEN_SHORT_MIN) begin
      t = {2'h0, ad[9:2]};
    end else if (len == (`LEN_SHORT_MIN + 5'h01)) begin
      t = {1'h0, ad[9:1]};
    end
    if ((ad != 10'h000) && (t == 10'h000)) begin
      t = 10'h001;
    end
    return t;
  endfunction

  // Clear every bit at or above the reply length
  function automatic logic [15:0] fit_length(
    input logic [15:0] word,
    input logic [4:0]  len
  );
    logic [15:0] m;
    m = word;
    for (int i = 0; i < 16; i++) begin
      if (i >= int'(len)) begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction

  // ************************************************************
  // Configuration registers
  // ************************************************************

  logic [1:0]  formatCtrl;
  logic [7:0]  deviceConfigWord;
  logic [1:0]  attributeBits;
  logic [3:0]  deviceAddr;
  logic [7:0]  replyCount;
  logic [7:0]  discardCount;

  always_ff @(posedge clk) begin
    if (srst) begin
      formatCtrl <= `RST_FORMAT_CTRL;
    end else if (regWrite && (regAddr == `OFS_FORMAT_CTRL)) begin
      formatCtrl <= regWrData[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      deviceConfigWord <= `RST_DEVICE_CFG;
    end else if (regWrite && (regAddr == `OFS_DEVICE_CFG)) begin
      deviceConfigWord <= regWrData[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      attributeBits <= `RST_DEVICE_CFG_ONE;
    end else if (regWrite && (regAddr == `OFS_DEVICE_CFG_ONE)) begin
      attributeBits <= regWrData[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      deviceAddr <= `RST_DEVICE_ADDR;
    end else if (regWrite && (regAddr == `OFS_DEVICE_ADDR)) begin
      deviceAddr <= regWrData[3:0];
    end
  end

  // ************************************************************
  // Command capture and acceptance
  // ************************************************************

  state_type   state;
  command_type held;
  logic        formatOk;
  logic        addrOk;
  logic        isAccel;
  logic        isIdQuery;
  logic        isLong;
  logic        accept;

  // The data byte is kept only so the capture stays whole; it takes no
  // part in the decode because its sole use is the CRC outside
  always_ff @(posedge clk) begin
    if (srst) begin
      held <= '0;
    end else if (cmdValid && (state == ST_IDLE)) begin
      held <= cmd;
    end
  end

  always_comb begin
    formatOk = 1'b0;
    case (held.format)
      FMT_STD_LONG: begin
        formatOk = 1'b1;
      end
      FMT_STD_SHORT: begin
        formatOk = 1'b1;
      end
      FMT_ENH_LONG: begin
        formatOk = formatCtrl[`POS_ENH_LONG];
      end
      FMT_ENH_SHORT: begin
        formatOk = formatCtrl[`POS_ENH_SHORT];
      end
      default: begin
        formatOk = 1'b0;
      end
    endcase
  end

  // Broadcast never matches: a reply from every node at once would collide
  assign addrOk    = (held.addr == deviceAddr)
                   && (held.addr != `GLOBAL_ADDR);
  assign isAccel   = (held.code == `CODE_READ_ACCEL);
  assign isIdQuery = (held.code == `CODE_REQUEST_ID);
  assign isLong    = (held.format == FMT_STD_LONG)
                   || (held.format == FMT_ENH_LONG);
  // Code 0011 and every other code fall through without a reply
  assign accept    = held.crcOk && formatOk && addrOk
                   && (isAccel || isIdQuery);

  // ************************************************************
  // Sequencing
  // ************************************************************

  // Commands arriving while a reply is being built are dropped; the
  // framing logic cannot deliver two within three cycles anyway
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmdValid) begin
            state <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          state <= ST_REPLY;
        end
        ST_REPLY: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Reply formatting
  // ************************************************************

  logic [4:0]  replyLen;
  logic [9:0]  accelCode;
  logic [14:0] accelShortFull;
  logic [15:0] accelWord;
  logic [4:0]  idField;
  logic [15:0] idWord;
  logic        accept_d;
  response_type next_resp;

  // Long commands always get the 16-bit reply; short ones follow the
  // received length within the short range
  always_comb begin
    if (isLong) begin
      replyLen = `LEN_LONG;
    end else if (held.len < `LEN_SHORT_MIN) begin
      replyLen = `LEN_SHORT_MIN;
    end else if (held.len > `LEN_SHORT_MAX) begin
      replyLen = `LEN_SHORT_MAX;
    end else begin
      replyLen = held.len;
    end
  end

  // Result is offset binary from the measurement path; zero stays
  // zero so a sensor error still reads as code 0
  assign accelCode = truncate_accel(accelResult, replyLen);

  // Padding order above the result: error, zero, self-test, attributes
  assign accelShortFull = {attributeBits,
                           selfTestActive,
                           1'b0,
                           internalError,
                           accelCode};

  always_comb begin
    if (isLong) begin
      accelWord = {deviceAddr, 1'b0, internalError, accelCode};
    end else if (replyLen < `LEN_FULL_ACCEL) begin
      accelWord = {6'h00, accelCode};
    end else begin
      accelWord = fit_length({1'b0, accelShortFull}, replyLen);
    end
  end

  // Only bit 3 follows the configuration; bit 4 is forced to zero and bits 2:0 are the fixed identifier
  always_comb begin
    idField    = ID_BASE;
    idField[3] = deviceConfigWord[`POS_ID_SELECT];
    idField[4] = 1'b0;
  end

  // Version sits directly on the five-bit identifier, whose top bit is
  // always zero; a gap between them would push the version into bits
  // that the shortest replies cut away
  always_comb begin
    if (isLong) begin
      idWord = {deviceAddr, 4'h0, VERSION_ID, idField};
    end else begin
      idWord = fit_length({8'h00, VERSION_ID, idField}, replyLen);
    end
  end

  always_comb begin
    next_resp.len = replyLen;
    if (isAccel) begin
      next_resp.data = accelWord;
    end else begin
      next_resp.data = idWord;
    end
  end

  // ************************************************************
  // Reply outputs
  // ************************************************************

  always_ff @(posedge clk) begin
    if (srst) begin
      accept_d <= 1'b0;
    end else begin
      accept_d <= (state == ST_DECIDE) && accept;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      resp <= '0;
    end else if ((state == ST_DECIDE) && accept) begin
      resp <= next_resp;
    end
  end

  // Bus stays quiet unless every check passed
  always_ff @(posedge clk) begin
    if (srst) begin
      respValid <= 1'b0;
    end else begin
      respValid <= (state == ST_DECIDE) && accept;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmdDiscard <= 1'b0;
    end else begin
      cmdDiscard <= (state == ST_DECIDE) && !accept;
    end
  end

  // ************************************************************
  // Activity counters
  // ************************************************************

  // Counters wrap; software takes differences between reads
  always_ff @(posedge clk) begin
    if (srst) begin
      replyCount <= 8'h00;
    end else if (accept_d) begin
      replyCount <= replyCount + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      discardCount <= 8'h00;
    end else if (cmdDiscard) begin
      discardCount <= discardCount + 8'h01;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************

  logic [15:0] next_regRdData;

  always_comb begin
    if (regAddr == `OFS_FORMAT_CTRL) begin
      next_regRdData = {14'h0000, formatCtrl};
    end else if (regAddr == `OFS_DEVICE_CFG) begin
      next_regRdData = {8'h00, deviceConfigWord};
    end else if (regAddr == `OFS_DEVICE_CFG_ONE) begin
      next_regRdData = {14'h0000, attributeBits};
    end else if (regAddr == `OFS_DEVICE_ADDR) begin
      next_regRdData = {12'h000, deviceAddr};
    end else if (regAddr == `OFS_LAST_RESPONSE) begin
      next_regRdData = resp.data;
    end else if (regAddr == `OFS_RESPONSE_LEN) begin
      next_regRdData = {11'h000, resp.len};
    end else if (regAddr == `OFS_COUNTERS) begin
      next_regRdData = {discardCount, replyCount};
    end else begin
      next_regRdData = 16'h0000;
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      regRdData <= next_regRdData;
    end else begin
      regRdData <= 16'h0000;
    end
  end

endmodule

// >>> tb/accel_response_id_query_props.sv
// Checker of the response slice, bound to its top-level ports.
// Assumes commands are spaced at least three cycles apart.
`timescale 1ns/1ps
module accel_response_id_query_props
  import accel_id_pkg::*;
#(
  parameter int ACCEL_WIDTH = 10
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   srst,
  // Command side
  input wire logic                   cmdValid,
  input command_type                 cmd,
  input wire logic [ACCEL_WIDTH-1:0] accelResult,
  input wire logic                   internalError,
  // Reply side
  input wire logic                   respValid,
  input response_type                resp,
  input wire logic                   cmdDiscard
);
  // ****************
  // Reply rules
  // ****************
  logic [4:0] clampLen;
  assign clampLen = (cmd.len < 5'h08) ? 5'h08 : ((cmd.len > 5'h0f) ? 5'h0f : cmd.len);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence longCmd;
    cmdValid && cmd.format inside {FMT_STD_LONG, FMT_ENH_LONG};
  endsequence
  sequence shortCmd;
    cmdValid && cmd.format inside {FMT_STD_SHORT, FMT_ENH_SHORT};
  endsequence
  a_unimpl_code_dropped:
    assert property (cmdValid && cmd.code == 4'h3 |-> ##2 cmdDiscard && !respValid)
    else $error("unimplemented code answered");
  a_bcast_id_dropped:
    assert property (cmdValid && cmd.code == 4'h4 && cmd.addr == 4'h0 |-> ##2 cmdDiscard)
    else $error("broadcast query answered");
  a_bad_crc_dropped:
    assert property (cmdValid && !cmd.crcOk |-> ##2 cmdDiscard && !respValid)
    else $error("bad check word answered");
  a_long_len_sixteen:
    assert property (longCmd ##2 respValid |-> resp.len == 5'h10)
    else $error("long reply length wrong");
  a_long_addr_field:
    assert property (longCmd ##2 respValid |-> resp.data[15:12] == $past(cmd.addr, 2))
    else $error("long reply address wrong");
  a_accel_long_body:
    assert property (cmdValid && cmd.code == 4'h2 && cmd.format inside {FMT_STD_LONG,
      FMT_ENH_LONG} ##2 respValid |-> resp.data[11:0] == {1'b0, $past(internalError),
      $past(accelResult)})
    else $error("acceleration reply body wrong");
  a_short_len_clamp:
    assert property (shortCmd ##2 respValid |-> resp.len == $past(clampLen, 2))
    else $error("short reply length wrong");
  a_reply_has_cause:
    assert property (respValid || cmdDiscard |-> $past(cmdValid, 2) && !(respValid && cmdDiscard))
    else $error("reply without command");
endmodule

bind accel_response_id_query accel_response_id_query_props #(.ACCEL_WIDTH(ACCEL_WIDTH)) i_props (
  .clk(clk), .srst(srst), .cmdValid(cmdValid), .cmd(cmd), .accelResult(accelResult),
  .internalError(internalError), .respValid(respValid), .resp(resp), .cmdDiscard(cmdDiscard));

// >>> tb/accel_bus_master.sv
// Bus master controller model: issues one decoded command, awaits reply.
// Assumes the slice answers within a few cycles of taking a command.
`timescale 1ns/1ps
module accel_bus_master
  import accel_id_pkg::*;
(
  // Clock
  input wire logic    clk,
  // Command toward the slice
  output command_type cmd,
  output logic        cmdValid,
  // Reply from the slice
  input response_type resp,
  input wire logic    respValid,
  input wire logic    cmdDiscard
);
  // ****************
  // Command issue
  // ****************
  logic [7:0] fill = 8'h00;
  initial begin
    cmdValid = 1'b0;
    cmd      = '0;
  end
  task automatic issue(input format_type f, input logic [3:0] a, input logic [3:0] c,
      input logic ok, input logic [4:0] n, input int gap,
      output logic got, output logic drop, output response_type r);
    command_type k;
    k    = '{format: f, addr: a, code: c, data: fill, crcOk: ok, len: n};
    got  = 1'b0;
    drop = 1'b0;
    r    = '0;
    fill = fill + 8'h5b; // Filler bits change every command
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd      <= k;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmd      <= command_type'(~k); // Released lines must not echo the old value
    for (int i = 0; i < 8 && !got && !drop; i++) begin
      @(negedge clk);
      got  = respValid;
      drop = cmdDiscard;
      r    = resp;
    end
  endtask
endmodule

// >>> tb/accel_response_id_query_test.sv
// Self-checking bench of the response slice and its register port.
// Assumes the bus master model and the bound checker are compiled.
`timescale 1ns/1ps
module accel_response_id_query_test
  import accel_id_pkg::*;
;
  // ****************
  // Bench setup
  // ****************
  localparam logic [2:0] VER = 3'h5;
  localparam logic [4:0] IDB = 5'h0a; // Arbitrary identifier value
  logic         clk, srst, cmdValid, internalError, selfTestActive, respValid, cmdDiscard;
  logic         regWrite, regRead, got, drop;
  command_type  cmd;
  response_type resp, r;
  logic [9:0]   accelResult;
  logic [3:0]   regAddr;
  logic [15:0]  regWrData, regRdData;
  int           failures = 0;
  int           checked = 0;
  int           ns[10] = '{6, 8, 9, 10, 11, 12, 13, 14, 15, 20};
  logic [9:0]   ads[4] = '{10'h2c7, 10'h003, 10'h000, 10'h200};
  accel_response_id_query #(.ACCEL_WIDTH(10), .VERSION_ID(VER), .ID_BASE(IDB)) i_dut (
    .clk(clk), .srst(srst), .cmdValid(cmdValid), .cmd(cmd), .accelResult(accelResult),
    .internalError(internalError), .selfTestActive(selfTestActive), .respValid(respValid),
    .resp(resp), .cmdDiscard(cmdDiscard), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  accel_bus_master i_master (.clk(clk), .cmd(cmd), .cmdValid(cmdValid), .resp(resp),
    .respValid(respValid), .cmdDiscard(cmdDiscard));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRdData, e);
  endtask
  // Short replies keep the low bits of the full word; lengths outside 8..15 clamp
  function automatic logic [15:0] mask(input int n);
    int c;
    c = (n < 8) ? 8 : ((n > 15) ? 15 : n);
    return (16'h0001 << c) - 16'h0001;
  endfunction
  task automatic send(input format_type f, input logic [3:0] a, input logic [3:0] c,
      input logic ok, input int n, input logic ev, input logic [15:0] ed);
    i_master.issue(f, a, c, ok, n[4:0], n % 3, got, drop, r);
    if (!(got || drop)) begin
      failures++;
      results();
    end
    chk({15'h0, got}, {15'h0, ev});
    chk({15'h0, drop}, {15'h0, !ev});
    if (ev) begin
      chk(r.data, ed);
      chk({11'h0, r.len}, (f inside {FMT_STD_LONG, FMT_ENH_LONG}) ? 16'h0010
        : 16'((n < 8) ? 8 : ((n > 15) ? 15 : n)));
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    for (int i = 0; i < 4; i++) rd(i[3:0], 16'h0000);
    rd(4'hf, 16'h0000);
    wr(4'h3, 16'h0005);
    wr(4'h1, 16'h0080);
    wr(4'h2, 16'h0002);
    wr(4'h4, 16'hffff);
    rd(4'h3, 16'h0005);
    rd(4'h2, 16'h0002);
    rd(4'h1, 16'h0080);
    rd(4'h4, 16'h0000);
  endtask
  task automatic t_reject();
    send(FMT_ENH_LONG, 4'h5, 4'h2, 1'b1, 16, 1'b0, 16'h0000);
    send(FMT_STD_LONG, 4'h6, 4'h4, 1'b1, 16, 1'b0, 16'h0000);
    send(FMT_STD_LONG, 4'h5, 4'h2, 1'b0, 16, 1'b0, 16'h0000);
    wr(4'h3, 16'h0000);
    send(FMT_STD_SHORT, 4'h0, 4'h4, 1'b1, 8, 1'b0, 16'h0000);
    wr(4'h3, 16'h0005);
    wr(4'h0, 16'h0003);
    for (int i = 0; i < 4; i++) send(format_type'(4'h1 << i), 4'h5, 4'h3, 1'b1, 16, 1'b0,
      16'h0000);
  endtask
  task automatic t_accel();
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      accelResult    <= ads[i];
      internalError  <= ~i[0];
      selfTestActive <= i[1];
      send(FMT_ENH_LONG, 4'h5, 4'h2, 1'b1, 16, 1'b1, {4'h5, 1'b0, ~i[0], ads[i]});
      for (int j = 0; j < 10; j++) begin
        e = {1'b0, 2'b10, i[1], 1'b0, ~i[0], ads[i]} & mask(ns[j]);
        if (ns[j] <= 8) e = {8'h00, ads[i][9:2]};
        if (ns[j] == 9) e = {7'h00, ads[i][9:1]};
        if (e == 16'h0000 && ads[i] != 10'h000) e = 16'h0001;
        send(format_type'(4'h2 << (j % 2) * 2), 4'h5, 4'h2, 1'b1, ns[j], 1'b1,
          e);
      end
    end
  endtask
  task automatic t_id();
    for (int b = 1; b >= 0; b--) begin
      wr(4'h1, {8'h00, b[0], 7'h00});
      for (int i = 0; i < 4; i++) send(format_type'(4'h1 << i), 4'h5, 4'h4, 1'b1, 12,
        1'b1, ({4'h5, 4'h0, VER, 1'b0, b[0], IDB[2:0]}) & ((i % 2) ? mask(12)
        : 16'hffff));
    end
  endtask
  task automatic t_status();
    rd(4'h0, 16'h0003);
    rd(4'h4, 16'h00a2);
    rd(4'h5, 16'h000c);
    rd(4'h6, 16'h0834);
  endtask
  initial begin
    srst           = 1'b1;
    internalError  = 1'b0;
    selfTestActive = 1'b0;
    accelResult    = 10'h000;
    regWrite       = 1'b0;
    regRead        = 1'b0;
    regAddr        = 4'h0;
    regWrData      = 16'h0000;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_reject();
    t_accel();
    t_id();
    t_status();
    results();
  end
endmodule
